// ---- spi_frame_if.sv ----
// Carrier between the serial frame receiver and the register bank.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ns
interface spi_frame_if;
	import vco_cal_pkg::*;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic wr_stb;
	logic [DATA_W-1:0] rdata;

	modport rx (output addr, output wdata, output wr_stb, input rdata);
	modport regs (input addr, input wdata, input wr_stb, output rdata);
endinterface

// ---- spi_frame_rx.sv ----
// Serial programming port: synchronises the pins, shifts frames, reads back.
// Assumes sck is much slower than clk_sys (at least four clk_sys per half period).
`timescale 1ns/1ns
module spi_frame_rx
	import vco_cal_pkg::*;
(
	input wire logic clk_sys, // System clock
	input wire logic srst, // Synchronous reset
	input wire logic csb_n, // Chip select pin, low active
	input wire logic sck, // Serial clock pin
	input wire logic sdi, // Serial data pin
	output logic muxout, // Read-back data pin
	spi_frame_if.rx bus // Frame towards the register bank
);
	// ==================================================================
	// Pin synchronisers, third stage only for edges
	logic [2:0] sck_ff, csb_ff;
	logic [1:0] sdi_ff;
	logic [FRAME_BITS-1:0] shin_ff;
	logic [4:0] cnt_ff;
	logic rw_ff;
	logic [ADDR_W-1:0] addr_ff;
	logic [DATA_W-1:0] shout_ff;
	logic wr_ff;
	wire sck_rise = sck_ff[1] & ~sck_ff[2];
	wire sck_fall = ~sck_ff[1] & sck_ff[2];
	wire sel = ~csb_ff[1];
	wire frame_end = csb_ff[1] & ~csb_ff[2];
	wire head_done = sck_rise & sel & (cnt_ff == HEAD_BITS - 5'h01);
	wire rd_load = sck_fall & sel & rw_ff & (cnt_ff == HEAD_BITS);
	wire rd_shift = sck_fall & sel & rw_ff & (cnt_ff > HEAD_BITS);

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			sck_ff <= 3'h0;
			csb_ff <= 3'h7;
			sdi_ff <= 2'h0;
		end else begin
			sck_ff <= {sck_ff[1:0], sck};
			csb_ff <= {csb_ff[1:0], csb_n};
			sdi_ff <= {sdi_ff[0], sdi};
		end
	end

	// ==================================================================
	// Shift in, count, latch head
	always_ff @(posedge clk_sys) begin
		if (srst || !sel) begin
			cnt_ff <= 5'h00;
		end else if (sck_rise && cnt_ff != FRAME_BITS) begin
			cnt_ff <= cnt_ff + 5'h01;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			shin_ff <= '0;
			rw_ff <= 1'b0;
			addr_ff <= '0;
		end else begin
			if (sck_rise && sel) shin_ff <= {shin_ff[FRAME_BITS-2:0], sdi_ff[1]};
			if (head_done) begin
				rw_ff <= shin_ff[RW_BIT-1];
				addr_ff <= {shin_ff[HEAD_ADDR_MSB-1:0], sdi_ff[1]};
			end
		end
	end

	// ==================================================================
	// Write only on a complete write frame; short frames are dropped
	always_ff @(posedge clk_sys) begin
		if (srst) wr_ff <= 1'b0;
		else wr_ff <= frame_end & (cnt_ff == FRAME_BITS) & ~shin_ff[FRAME_BITS-1];
	end

	always_ff @(posedge clk_sys) begin
		if (srst) shout_ff <= '0;
		else if (rd_load) shout_ff <= bus.rdata;
		else if (rd_shift) shout_ff <= {shout_ff[DATA_W-2:0], 1'b0};
	end

	assign muxout = shout_ff[DATA_W-1];
	assign bus.addr = addr_ff;
	assign bus.wdata = shin_ff[DATA_W-1:0];
	assign bus.wr_stb = wr_ff;
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the oscillator calibration register bank.
// Assumes the serial frame port is the only way to reach the registers.
`timescale 1ns/1ns
`define CHK(got, exp, msg) begin num_checks++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("MISMATCH %0t %s", $time, msg); end end
module tb_top;
	import vco_cal_pkg::*;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic csb_n = 1'b1;
	logic sck = 1'b0;
	logic sdi = 1'b0;
	logic amplitude_cal_enable = 1'b0;
	logic frequency_cal_enable = 1'b0;
	logic capacitor_code_override = 1'b0;
	logic muxout, acal_run, acal_search_up, start_code_illegal, fcal_run, cap_code_in_core, core_force_active;
	logic [AMP_START_W-1:0] acal_seed;
	logic [CORE_W-1:0] fcal_start_core, active_core;
	logic [CAP_W-1:0] capacitor_bank_code;
	logic [DATA_W-1:0] rd;
	logic [ADDR_W-1:0] ta [6] = '{OFS_AMP_START, OFS_CAP_CODE, OFS_CORE_SEL, OFS_RSV_A, OFS_RSV_B, OFS_RSV_C};
	logic [DATA_W-1:0] tp [6] = '{16'hA1C2, 16'h5A3C, 16'hC3A5, 16'h1234, 16'hFEDC, 16'h8001};
	logic [AMP_START_W-1:0] sv [5] = '{9'h0F9, 9'h0FA, 9'h1C2, 9'h1C3, 9'h12C};
	logic [AMP_START_W-1:0] se [5] = '{9'h0FA, 9'h0FA, 9'h1C2, 9'h0FA, 9'h12C};
	logic si [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
	logic [CAP_W-1:0] cv [4] = '{8'h00, 8'hB7, 8'hB8, 8'hFF};
	logic ci [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
	int n_mismatch = 0;
	int num_checks = 0;

	// ==================================================================
	// Clock and design
	always #20 clk_sys = ~clk_sys;

	vco_calibration_control_regs uut (
		.clk_sys(clk_sys), .srst(srst), .csb_n(csb_n), .sck(sck), .sdi(sdi), .muxout(muxout),
		.amplitude_cal_enable(amplitude_cal_enable), .frequency_cal_enable(frequency_cal_enable),
		.capacitor_code_override(capacitor_code_override), .acal_run(acal_run), .acal_seed(acal_seed),
		.acal_search_up(acal_search_up), .start_code_illegal(start_code_illegal), .fcal_run(fcal_run),
		.fcal_start_core(fcal_start_core), .capacitor_bank_code(capacitor_bank_code),
		.cap_code_in_core(cap_code_in_core), .core_force_active(core_force_active), .active_core(active_core)
	);

	// ==================================================================
	// Serial access tasks
	task cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// High phase of five clocks (low phase eleven) leaves margin over the three-stage sampling
	task frame(input logic [23:0] f, input int nbits);
		int k;
		rd = RDATA_NONE;
		@(posedge clk_sys) csb_n <= 1'b0;
		cyc(5);
		for (k = 0; k < nbits; k++) begin
			sdi <= f[23-k];
			cyc(5);
			@(negedge clk_sys);
			if (k >= 8) rd[23-k] = muxout;
			@(posedge clk_sys) sck <= 1'b1;
			cyc(5);
			sck <= 1'b0;
			cyc(5);
		end
		csb_n <= 1'b1;
		sdi <= 1'b0;
		cyc(10);
		@(negedge clk_sys);
	endtask

	task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		frame({1'b0, a, d}, 24);
	endtask

	task rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		frame({1'b1, a, RDATA_NONE}, 24);
		`CHK(rd, exp, "register read back")
	endtask

	task drive(input logic ae, input logic fe, input logic ov);
		@(posedge clk_sys);
		amplitude_cal_enable <= ae;
		frequency_cal_enable <= fe;
		capacitor_code_override <= ov;
		cyc(3);
		@(negedge clk_sys);
	endtask

	task end_sim;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ==================================================================
	// Hang guard
	initial begin
		#3000000;
		n_mismatch++;
		$display("MISMATCH %0t run did not finish", $time);
		end_sim();
	end

	// ==================================================================
	// Sequence
	initial begin
		cyc(4);
		srst <= 1'b0;
		cyc(4);
		@(negedge clk_sys);
		`CHK(acal_seed, AMP_START_RST, "seed after reset")
		`CHK(acal_search_up, 1'b1, "search direction")
		`CHK(fcal_start_core, DEFAULT_START_CORE, "start core after reset")
		`CHK(capacitor_bank_code, 8'h00, "capacitor code after reset")
		`CHK(cap_code_in_core, 1'b1, "in-core after reset")
		`CHK(core_force_active, 1'b0, "force after reset")
		`CHK(active_core, CORE_NONE, "active core after reset")
		rchk(OFS_AMP_START, REG_AMP_RST);
		rchk(OFS_CAP_CODE, REG_CAP_RST);
		rchk(OFS_CORE_SEL, REG_CORE_RST);
		for (int i = 3; i < 6; i++) rchk(ta[i], REG_RSV_RST);
		// Every bit stores, unnamed ones too, so software can restore defaults
		for (int i = 0; i < 6; i++) begin
			wr(ta[i], tp[i]);
			rchk(ta[i], tp[i]);
		end
		wr(7'h15, 16'hFFFF);
		rchk(7'h15, RDATA_NONE);
		rchk(OFS_CAP_CODE, tp[1]);
		frame({1'b1, OFS_CAP_CODE, 16'h00FF}, 24);
		rchk(OFS_CAP_CODE, tp[1]);
		frame({1'b0, OFS_CAP_CODE, 16'h0011}, 23);
		rchk(OFS_CAP_CODE, tp[1]);
		// Both ends of the legal window and one value just past each, then the suggested seed
		for (int i = 0; i < 5; i++) begin
			wr(OFS_AMP_START, {7'h00, sv[i]});
			`CHK(acal_seed, se[i], "amplitude seed")
			`CHK(start_code_illegal, si[i], "start code window")
			`CHK(acal_search_up, 1'b1, "search upward")
		end
		for (int i = 0; i < 4; i++) begin
			wr(OFS_CAP_CODE, {8'h00, cv[i]});
			`CHK(capacitor_bank_code, cv[i], "capacitor code")
			`CHK(cap_code_in_core, ci[i], "in-core range")
		end
		wr(OFS_CORE_SEL, 16'h1800);
		`CHK(fcal_start_core, DEFAULT_START_CORE, "start core without flag")
		wr(OFS_CORE_SEL, 16'h5800);
		`CHK(fcal_start_core, 3'h3, "start core from select")
		wr(OFS_CORE_SEL, 16'h4000);
		`CHK(fcal_start_core, 3'h0, "start core zero")
		wr(OFS_CORE_SEL, 16'h2C00);
		drive(1'b0, 1'b1, 1'b1);
		`CHK(core_force_active, 1'b1, "forced core")
		`CHK(active_core, 3'h5, "forced core number")
		`CHK(fcal_run, 1'b0, "calibration bypassed")
		`CHK(acal_run, 1'b0, "amplitude idle")
		drive(1'b1, 1'b1, 1'b0);
		`CHK(core_force_active, 1'b0, "no force without override")
		`CHK(active_core, CORE_NONE, "no core without override")
		`CHK(fcal_run, 1'b1, "calibration runs")
		`CHK(acal_run, 1'b1, "amplitude runs")
		// Force written while override already holds, then dropped by a later write
		drive(1'b0, 1'b0, 1'b1);
		wr(OFS_CORE_SEL, 16'h3400);
		`CHK(core_force_active, 1'b1, "force follows write")
		`CHK(active_core, 3'h6, "forced core follows write")
		wr(OFS_CORE_SEL, 16'h2800);
		`CHK(core_force_active, 1'b0, "no force without force bit")
		`CHK(active_core, CORE_NONE, "core idle without force bit")
		end_sim();
	end
endmodule

// ---- vco_cal_pkg.sv ----
// Constants for the oscillator calibration register bank.
// Assumes a 16-bit register word and a 24-bit serial frame, MSB first.
package vco_cal_pkg;

	// ==================================================================
	// Serial frame layout
	localparam int ADDR_W = 7;
	localparam int DATA_W = 16;
	localparam logic [4:0] FRAME_BITS = 5'h18;
	localparam logic [4:0] HEAD_BITS = 5'h08;
	localparam int RW_BIT = 7;
	localparam int HEAD_ADDR_MSB = 6;

	// ==================================================================
	// Register offsets
	localparam logic [ADDR_W-1:0] OFS_AMP_START = 7'h14;
	localparam logic [ADDR_W-1:0] OFS_CAP_CODE = 7'h16;
	localparam logic [ADDR_W-1:0] OFS_CORE_SEL = 7'h17;
	localparam logic [ADDR_W-1:0] OFS_RSV_A = 7'h18;
	localparam logic [ADDR_W-1:0] OFS_RSV_B = 7'h19;
	localparam logic [ADDR_W-1:0] OFS_RSV_C = 7'h1C;

	// ==================================================================
	// Field positions and widths
	localparam int AMP_START_LSB = 0;
	localparam int AMP_START_W = 9;
	localparam int CAP_LSB = 0;
	localparam int CAP_W = 8;
	localparam int FORCE_BIT = 10;
	localparam int CORE_SEL_LSB = 11;
	localparam int CORE_W = 3;
	localparam int START_CORE_BIT = 14;

	// ==================================================================
	// Reset values and limits
	localparam logic [AMP_START_W-1:0] AMP_START_RST = 9'h12C;
	localparam logic [AMP_START_W-1:0] AMP_CODE_MIN = 9'h0FA;
	localparam logic [AMP_START_W-1:0] AMP_CODE_MAX = 9'h1C2;
	localparam logic [CAP_W-1:0] CAP_IN_CORE_MAX = 8'hB7;
	localparam logic [CORE_W-1:0] CORE_SEL_RST = 3'h1;
	localparam logic [CORE_W-1:0] DEFAULT_START_CORE = 3'h7;
	localparam logic [CORE_W-1:0] CORE_NONE = 3'h0;
	localparam logic [DATA_W-1:0] REG_AMP_RST = 16'h012C;
	localparam logic [DATA_W-1:0] REG_CAP_RST = 16'h0000;
	localparam logic [DATA_W-1:0] REG_CORE_RST = 16'h0800;
	localparam logic [DATA_W-1:0] REG_RSV_RST = 16'h0000;
	localparam logic [DATA_W-1:0] RDATA_NONE = 16'h0000;

endpackage

// ---- vco_calibration_control_regs.sv ----
// Oscillator calibration register bank and the steering it gives the engines.
// Assumes calibration engines and neighbouring control logic run on clk_sys.
//
// Operation
// R01: Nine-bit start code for amplitude calibration, read/write, resets to 300.
// R02: Default amplitude search starts at low end and steps upward.
// R03: Software keeps the amplitude start code between 250 and 450.
// R04: Start code near the final result shortens amplitude calibration.
// R05: Eight-bit capacitor code sets frequency directly when override is set.
// R06: Capacitor codes 0 to 183 stay inside the chosen core.
// R07: Manual capacitor use also needs core force and core select written.
// R08: Start-core flag bit 14 makes calibration start at selected core.
// R09: Without start-core flag, frequency calibration starts at core 7 downward.
// R10: Three-bit core select bits 13:11, reset 1, picks forced and start core.
// R11: Core force bit 10 applies core select together with override.
// R12: Software writes unnamed and reserved bits with their default values.
`timescale 1ns/1ns
module vco_calibration_control_regs
	import vco_cal_pkg::*;
#(
	parameter logic [DATA_W-1:0] RSV_A_RST = REG_RSV_RST,
	parameter logic [DATA_W-1:0] RSV_B_RST = REG_RSV_RST,
	parameter logic [DATA_W-1:0] RSV_C_RST = REG_RSV_RST
)
(
	input wire logic clk_sys, // System clock
	input wire logic srst, // Synchronous reset
	input wire logic csb_n, // Serial chip select, low active
	input wire logic sck, // Serial clock
	input wire logic sdi, // Serial data in
	output logic muxout, // Serial read-back data
	input wire logic amplitude_cal_enable, // Amplitude calibration wanted
	input wire logic frequency_cal_enable, // Frequency calibration wanted
	input wire logic capacitor_code_override, // Manual capacitor code in force
	output logic acal_run, // Amplitude engine may run
	output logic [AMP_START_W-1:0] acal_seed, // First amplitude code to try
	output logic acal_search_up, // Amplitude search direction upward
	output logic start_code_illegal, // Start code outside legal window
	output logic fcal_run, // Frequency engine may run
	output logic [CORE_W-1:0] fcal_start_core, // Core the frequency search starts at
	output logic [CAP_W-1:0] capacitor_bank_code, // Capacitor code to oscillator
	output logic cap_code_in_core, // Code lies within one core's range
	output logic core_force_active, // Forced core in effect
	output logic [CORE_W-1:0] active_core // Forced core, zero when not forced
);
	// ==================================================================
	// Serial port
	spi_frame_if bus ();

	spi_frame_rx u_rx (
		.clk_sys(clk_sys),
		.srst(srst),
		.csb_n(csb_n),
		.sck(sck),
		.sdi(sdi),
		.muxout(muxout),
		.bus(bus)
	);

	// ==================================================================
	// Register storage; unnamed bits are stored as written
	logic [DATA_W-1:0] amp_cal_start_code_ff;
	logic [DATA_W-1:0] osc_capacitor_code_ff;
	logic [DATA_W-1:0] osc_core_selection_ff;
	logic [DATA_W-1:0] reserved_cfg_a_ff;
	logic [DATA_W-1:0] reserved_cfg_b_ff;
	logic [DATA_W-1:0] reserved_cfg_c_ff;

	wire hit_amp = bus.addr == OFS_AMP_START;
	wire hit_cap = bus.addr == OFS_CAP_CODE;
	wire hit_core = bus.addr == OFS_CORE_SEL;
	wire hit_rsv_a = bus.addr == OFS_RSV_A;
	wire hit_rsv_b = bus.addr == OFS_RSV_B;
	wire hit_rsv_c = bus.addr == OFS_RSV_C;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			amp_cal_start_code_ff <= REG_AMP_RST; // R01
			osc_capacitor_code_ff <= REG_CAP_RST; // R05
			osc_core_selection_ff <= REG_CORE_RST; // R10
		end else if (bus.wr_stb) begin
			if (hit_amp) amp_cal_start_code_ff <= bus.wdata; // R01
			if (hit_cap) osc_capacitor_code_ff <= bus.wdata; // R05
			if (hit_core) osc_core_selection_ff <= bus.wdata; // R10
		end
	end

	// Reserved words kept so software reading back sees what it wrote
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			reserved_cfg_a_ff <= RSV_A_RST;
			reserved_cfg_b_ff <= RSV_B_RST;
			reserved_cfg_c_ff <= RSV_C_RST;
		end else if (bus.wr_stb) begin
			if (hit_rsv_a) reserved_cfg_a_ff <= bus.wdata;
			if (hit_rsv_b) reserved_cfg_b_ff <= bus.wdata;
			if (hit_rsv_c) reserved_cfg_c_ff <= bus.wdata;
		end
	end

	// Unmapped addresses read as zero
	assign bus.rdata = hit_amp ? amp_cal_start_code_ff :
		hit_cap ? osc_capacitor_code_ff :
		hit_core ? osc_core_selection_ff :
		hit_rsv_a ? reserved_cfg_a_ff :
		hit_rsv_b ? reserved_cfg_b_ff :
		hit_rsv_c ? reserved_cfg_c_ff : RDATA_NONE;

	// ==================================================================
	// Field decode
	wire [AMP_START_W-1:0] start_code = amp_cal_start_code_ff[AMP_START_LSB +: AMP_START_W];
	wire [CAP_W-1:0] cap_code = osc_capacitor_code_ff[CAP_LSB +: CAP_W];
	wire [CORE_W-1:0] core_select = osc_core_selection_ff[CORE_SEL_LSB +: CORE_W];
	wire core_force = osc_core_selection_ff[FORCE_BIT];
	wire cal_start_core_enable = osc_core_selection_ff[START_CORE_BIT];

	// Illegal code is not trusted; search falls back to the low end
	wire start_legal = (start_code >= AMP_CODE_MIN) && (start_code <= AMP_CODE_MAX); // R03
	wire [AMP_START_W-1:0] nxt_seed = start_legal ? start_code : AMP_CODE_MIN; // R02 R04
	wire nxt_in_core = cap_code <= CAP_IN_CORE_MAX; // R06
	wire nxt_forced = capacitor_code_override & core_force; // R07 R11
	wire [CORE_W-1:0] nxt_active = nxt_forced ? core_select : CORE_NONE; // R10
	wire [CORE_W-1:0] nxt_start_core = cal_start_core_enable ? core_select : DEFAULT_START_CORE; // R08 R09
	wire nxt_fcal_run = frequency_cal_enable & ~capacitor_code_override; // R05

	// ==================================================================
	// Registered steering outputs
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			acal_seed <= AMP_START_RST;
			acal_search_up <= 1'b1;
			start_code_illegal <= 1'b0;
			acal_run <= 1'b0;
		end else begin
			acal_seed <= nxt_seed; // R01 R04
			acal_search_up <= 1'b1; // R02
			start_code_illegal <= ~start_legal; // R03
			acal_run <= amplitude_cal_enable;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			fcal_run <= 1'b0;
			fcal_start_core <= DEFAULT_START_CORE;
			capacitor_bank_code <= REG_CAP_RST[CAP_LSB +: CAP_W];
			cap_code_in_core <= 1'b1;
			core_force_active <= 1'b0;
			active_core <= CORE_NONE;
		end else begin
			fcal_run <= nxt_fcal_run; // R05
			fcal_start_core <= nxt_start_core; // R08 R09
			capacitor_bank_code <= cap_code; // R05
			cap_code_in_core <= nxt_in_core; // R06
			core_force_active <= nxt_forced; // R11
			active_core <= nxt_active; // R10
		end
	end

	// ==================================================================
	// Assertions
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	sequence s_amp_write;
		bus.wr_stb && hit_amp && (bus.wdata[AMP_START_LSB +: AMP_START_W] >= AMP_CODE_MIN)
			&& (bus.wdata[AMP_START_LSB +: AMP_START_W] <= AMP_CODE_MAX);
	endsequence

	sequence s_seed_seen;
		##2 acal_seed == $past(bus.wdata[AMP_START_LSB +: AMP_START_W], 2);
	endsequence

	property p_amp_write;
		s_amp_write |-> s_seed_seen;
	endproperty
	a_amp_write: assert property (p_amp_write) else $error("start code write not seen at seed"); // R01

	property p_seed_low;
		!start_legal |=> (acal_seed == AMP_CODE_MIN) && start_code_illegal && acal_search_up;
	endproperty
	a_seed_low: assert property (p_seed_low) else $error("illegal start code did not fall back low"); // R02

	property p_seed_pass;
		start_legal |=> acal_seed == $past(start_code) && !start_code_illegal;
	endproperty
	a_seed_pass: assert property (p_seed_pass) else $error("legal start code not used as seed"); // R04

	property p_cap_out;
		##1 capacitor_bank_code == $past(cap_code);
	endproperty
	a_cap_out: assert property (p_cap_out) else $error("capacitor code not passed through"); // R05

	property p_fcal_bypass;
		capacitor_code_override |=> !fcal_run;
	endproperty
	a_fcal_bypass: assert property (p_fcal_bypass) else $error("frequency calibration ran under override"); // R05

	property p_in_core;
		##1 cap_code_in_core == ($past(cap_code) <= CAP_IN_CORE_MAX);
	endproperty
	a_in_core: assert property (p_in_core) else $error("in-core flag wrong for capacitor code"); // R06

	property p_start_core;
		cal_start_core_enable |=> fcal_start_core == $past(core_select);
	endproperty
	a_start_core: assert property (p_start_core) else $error("start core not taken from core select"); // R08

	property p_start_default;
		!cal_start_core_enable |=> fcal_start_core == DEFAULT_START_CORE;
	endproperty
	a_start_default: assert property (p_start_default) else $error("default start core not seven"); // R09

	sequence s_core_write;
		bus.wr_stb && hit_core && bus.wdata[FORCE_BIT] && capacitor_code_override;
	endsequence

	property p_forced_core;
		s_core_write ##1 capacitor_code_override |=>
			active_core == $past(bus.wdata[CORE_SEL_LSB +: CORE_W], 2);
	endproperty
	a_forced_core: assert property (p_forced_core) else $error("forced core does not follow write"); // R10

	property p_force;
		!(capacitor_code_override && core_force) |=> !core_force_active && (active_core == CORE_NONE);
	endproperty
	a_force: assert property (p_force) else $error("core forced without override and force"); // R11

	// ==================================================================
	// Register write checks
	// A stray strobe would move calibration settings under a running engine
	sequence s_amp_store;
		bus.wr_stb && hit_amp;
	endsequence

	property p_amp_store;
		s_amp_store |=> amp_cal_start_code_ff == $past(bus.wdata);
	endproperty
	a_amp_store: assert property (p_amp_store) else $error("start code register did not take write"); // R01

	property p_amp_hold;
		!(bus.wr_stb && hit_amp) |=> $stable(amp_cal_start_code_ff);
	endproperty
	a_amp_hold: assert property (p_amp_hold) else $error("start code register moved without write"); // R01

	sequence s_cap_store;
		bus.wr_stb && hit_cap;
	endsequence

	property p_cap_store;
		s_cap_store |=> osc_capacitor_code_ff == $past(bus.wdata);
	endproperty
	a_cap_store: assert property (p_cap_store) else $error("capacitor register did not take write"); // R05

	property p_cap_hold;
		!(bus.wr_stb && hit_cap) |=> $stable(osc_capacitor_code_ff);
	endproperty
	a_cap_hold: assert property (p_cap_hold) else $error("capacitor register moved without write"); // R05

	sequence s_core_store;
		bus.wr_stb && hit_core;
	endsequence

	property p_core_store;
		s_core_store |=> osc_core_selection_ff == $past(bus.wdata);
	endproperty
	a_core_store: assert property (p_core_store) else $error("core register did not take write"); // R10

	property p_core_hold;
		!(bus.wr_stb && hit_core) |=> $stable(osc_core_selection_ff);
	endproperty
	a_core_hold: assert property (p_core_hold) else $error("core register moved without write"); // R10

	// ==================================================================
	// Steering checks
	// Seed stays inside the legal window whatever software wrote
	property p_seed_range;
		(acal_seed >= AMP_CODE_MIN) && (acal_seed <= AMP_CODE_MAX);
	endproperty
	a_seed_range: assert property (p_seed_range) else $error("seed outside legal code window"); // R04

	property p_illegal_seed;
		start_code_illegal |-> acal_seed == AMP_CODE_MIN;
	endproperty
	a_illegal_seed: assert property (p_illegal_seed) else $error("illegal flag without low-end seed"); // R02

	property p_acal_run;
		##1 acal_run == $past(amplitude_cal_enable);
	endproperty
	a_acal_run: assert property (p_acal_run) else $error("amplitude run does not follow enable"); // R02

	property p_fcal_run;
		frequency_cal_enable && !capacitor_code_override |=> fcal_run;
	endproperty
	a_fcal_run: assert property (p_fcal_run) else $error("frequency calibration held off without override"); // R05

	sequence s_forced;
		capacitor_code_override && core_force;
	endsequence

	property p_force_on;
		s_forced |=> core_force_active && (active_core == $past(core_select));
	endproperty
	a_force_on: assert property (p_force_on) else $error("forced core not applied"); // R11

	property p_active_free;
		!core_force_active |-> active_core == CORE_NONE;
	endproperty
	a_active_free: assert property (p_active_free) else $error("active core shown without force"); // R10

endmodule
